//--- ovs_guard_sw.sv
// One VBUS feed switch with continuous over-current trip timer
// Assumes over-current input already synchronised to core_clk
`timescale 1ns/1ps
`include "ovs_map.svh"
module ovs_guard_sw
  import ovs_pkg::*;
#(
  parameter int OC_CYCLES = `OVS_OC_CYCLES
) (
  input  wire logic core_clk, // System clock
  input  wire logic nrst,     // Sync reset, active low
  ovs_sw_if.ctl     sw        // Switch control bundle
);
  localparam int CW = $clog2(OC_CYCLES + 1);

  ovs_sw_state_t state_q;
  ovs_sw_state_t state_d;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          trip_q;
  wire           timeout;
  wire           run;

  assign run     = (state_q == OVS_SW_ON) && sw.allow;
  assign timeout = run && sw.oc_sync && (cnt_q >= CW'(OC_CYCLES));

  // ----------------------------------------
  // Overload timer and switch state
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    if (run && sw.oc_sync) begin
      if (cnt_q < CW'(OC_CYCLES)) begin
        cnt_d = cnt_q + CW'(1);
      end
    end else begin
      cnt_d = '0;
    end
    case (state_q)
      OVS_SW_OFF: begin
        if (sw.enable_req) begin
          state_d = OVS_SW_ON;
        end
      end
      OVS_SW_ON: begin
        if (!sw.enable_req) begin
          state_d = OVS_SW_OFF;
        end else if (timeout) begin
          state_d = OVS_SW_TRIPPED;
          cnt_d   = '0;
        end
      end
      OVS_SW_TRIPPED: begin
        if (sw.enable_rise) begin
          state_d = OVS_SW_ON;
        end
      end
      default: state_d = OVS_SW_OFF;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state_q <= OVS_SW_OFF;
      cnt_q   <= '0;
      trip_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      trip_q  <= timeout;
    end
  end

  assign sw.closed     = run;
  assign sw.trip_pulse = trip_q;
endmodule

//--- ovs_map.svh
// Constants for the OTG VBUS switch and source select block
// Assumes inclusion by bare name from the modules
`ifndef OVS_MAP_SVH
`define OVS_MAP_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define OVS_CTRL_OFS     4'h0
`define OVS_STAT_OFS     4'h4
`define OVS_IRQ_OFS      4'h8
`define OVS_MASK_OFS     4'hC

// ----------------------------------------
// Field positions
// ----------------------------------------
`define OVS_CTRL_BOOST_EN_BIT 0
`define OVS_CTRL_ADAPT_EN_BIT 1
`define OVS_MASK_BOOST_BIT    0
`define OVS_MASK_ADAPT_BIT    1
`define OVS_IRQ_BOOST_BIT     0
`define OVS_IRQ_ADAPT_BIT     1

// ----------------------------------------
// Reset values
// ----------------------------------------
`define OVS_CTRL_RST     2'h0
`define OVS_MASK_RST     2'h0
`define OVS_IRQ_RST      2'h0

// ----------------------------------------
// Timing
// ----------------------------------------
`define OVS_OC_TIME_MS   256
`define OVS_CLK_HZ       20000000
// Divide first so the product stays inside a 32-bit int
`define OVS_OC_CYCLES    (`OVS_OC_TIME_MS * (`OVS_CLK_HZ / 1000))

`endif

//--- ovs_pkg.sv
// Types for the OTG VBUS switch and source select block
// Assumes nothing beyond the map header
package ovs_pkg;
  typedef enum logic [1:0] {
    OVS_SRC_BATT  = 2'h0,
    OVS_SRC_VBUS  = 2'h1,
    OVS_SRC_ADAPT = 2'h3
  } ovs_src_t;

  typedef enum logic [1:0] {
    OVS_SW_OFF     = 2'h0,
    OVS_SW_ON      = 2'h1,
    OVS_SW_TRIPPED = 2'h3
  } ovs_sw_state_t;
endpackage

//--- ovs_sw_if.sv
// Interface between the top and one guarded switch
// Assumes the top drives the request side on core_clk
`timescale 1ns/1ps
interface ovs_sw_if;
  logic enable_req;
  logic allow;
  logic enable_rise;
  logic oc_sync;
  logic closed;
  logic trip_pulse;
  modport ctl (input enable_req, allow, enable_rise, oc_sync, output closed, trip_pulse);
  modport top (output enable_req, allow, enable_rise, oc_sync, input closed, trip_pulse);
endinterface

//--- ovs_top.sv
// Top of the OTG VBUS switch and source select block
// Assumes analog comparators arrive asynchronously; Avalon-MM master on core_clk
`timescale 1ns/1ps
`include "ovs_map.svh"
module ovs_top
  import ovs_pkg::*;
#(
  parameter int OC_CYCLES = `OVS_OC_CYCLES
) (
  input  wire logic        core_clk,          // System clock, 20 MHz
  input  wire logic        nrst,              // Sync reset, active low
  input  wire logic [3:0]  avs_address,       // Byte address
  input  wire logic        avs_read,          // Read strobe
  input  wire logic        avs_write,         // Write strobe
  input  wire logic [31:0] avs_writedata,     // Write data
  input  wire logic [3:0]  avs_byteenable,    // Byte enables
  output logic      [31:0] avs_readdata,      // Read data
  output logic             avs_waitrequest,   // Wait request
  output logic             avs_response_err,  // Unmapped access flag with answer
  input  wire logic        boost_oc_in,       // Boost switch over-current comparator
  input  wire logic        adapter_oc_in,     // Adapter switch over-current comparator
  input  wire logic        adapter_ov_in,     // Adapter above 6 V comparator
  input  wire logic        adapter_valid_in,  // Adapter input valid
  input  wire logic        vbus_valid_in,     // VBUS input valid
  input  wire logic        sys_overload_in,   // System load above input capability
  output logic             boost_to_vbus_switch,   // Boost feed to VBUS gate
  output logic             adapter_to_vbus_switch, // Adapter to VBUS gate
  output logic             vbus_charge_path,       // Charge path from VBUS
  output logic             adapter_charge_path,    // Charge path from adapter
  output logic             charge_enable,          // Battery charging on
  output logic             battery_supply,         // Battery feeds system
  output logic [1:0]       sys_source,             // Selected source code
  output logic             irq                     // Level interrupt
);
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  localparam int NS = 6;
  wire  [NS-1:0] async_in;
  logic [NS-1:0] meta_q;
  logic [NS-1:0] sync_q;
  assign async_in = {sys_overload_in, vbus_valid_in, adapter_valid_in,
                     adapter_ov_in, adapter_oc_in, boost_oc_in};

  genvar gi;
  generate
    for (gi = 0; gi < NS; gi++) begin : g_sync
      always_ff @(posedge core_clk) begin
        if (!nrst) begin
          meta_q[gi] <= 1'b0;
          sync_q[gi] <= 1'b0;
        end else begin
          meta_q[gi] <= async_in[gi];
          sync_q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

  wire boost_oc    = sync_q[0];
  wire adapter_oc  = sync_q[1];
  wire adapter_ov  = sync_q[2];
  wire adapter_ok  = sync_q[3];
  wire vbus_ok     = sync_q[4];
  wire sys_over    = sync_q[5];

  // ----------------------------------------
  // Register bus decode
  // ----------------------------------------
  logic [1:0]  ctrl_q;
  logic [1:0]  mask_q;
  logic [1:0]  irq_q;
  logic        ack_q;
  logic        wait_q;
  logic [31:0] rdata_q;
  logic        err_q;
  logic        rise_boost_q;
  logic        rise_adapt_q;

  wire req      = (avs_read || avs_write) && !ack_q;
  // Write lands at the edge where waitrequest is low
  wire wr_go    = avs_write && ack_q && avs_byteenable[0];
  wire sel_ctrl = avs_address == `OVS_CTRL_OFS;
  wire sel_stat = avs_address == `OVS_STAT_OFS;
  wire sel_irq  = avs_address == `OVS_IRQ_OFS;
  wire sel_mask = avs_address == `OVS_MASK_OFS;
  wire mapped   = sel_ctrl || sel_stat || sel_irq || sel_mask;
  wire wr_ctrl  = wr_go && sel_ctrl;
  wire wr_irq   = wr_go && sel_irq;
  wire wr_mask  = wr_go && sel_mask;

  wire [1:0] ctrl_new    = avs_writedata[1:0];
  wire       boost_rise  = wr_ctrl && !ctrl_q[`OVS_CTRL_BOOST_EN_BIT]
                           && ctrl_new[`OVS_CTRL_BOOST_EN_BIT];
  wire       adapt_rise  = wr_ctrl && !ctrl_q[`OVS_CTRL_ADAPT_EN_BIT]
                           && ctrl_new[`OVS_CTRL_ADAPT_EN_BIT];

  // ----------------------------------------
  // Guarded switches
  // ----------------------------------------
  ovs_sw_if boost_if ();
  ovs_sw_if adapt_if ();

  assign boost_if.enable_req  = ctrl_q[`OVS_CTRL_BOOST_EN_BIT];
  assign boost_if.allow       = 1'b1;
  assign boost_if.enable_rise = rise_boost_q;
  assign boost_if.oc_sync     = boost_oc;
  assign adapt_if.enable_req  = ctrl_q[`OVS_CTRL_ADAPT_EN_BIT];
  assign adapt_if.allow       = !boost_if.closed && !adapter_ov;
  assign adapt_if.enable_rise = rise_adapt_q;
  assign adapt_if.oc_sync     = adapter_oc;

  ovs_guard_sw #(.OC_CYCLES(OC_CYCLES)) u_boost_sw (
    .core_clk (core_clk),
    .nrst     (nrst),
    .sw       (boost_if)
  );

  ovs_guard_sw #(.OC_CYCLES(OC_CYCLES)) u_adapt_sw (
    .core_clk (core_clk),
    .nrst     (nrst),
    .sw       (adapt_if)
  );

  // ----------------------------------------
  // Fault flags, set wins over clear
  // ----------------------------------------
  wire [1:0] fault_set = {adapt_if.trip_pulse, boost_if.trip_pulse};
  wire [1:0] fault_clr = wr_irq ? avs_writedata[1:0] : 2'h0;
  wire [1:0] irq_d     = fault_set | (irq_q & ~fault_clr);
  wire       irq_d_out = |(irq_d & mask_q);

  // ----------------------------------------
  // Source selection
  // ----------------------------------------
  wire boost_closed = boost_if.closed;
  wire use_adapt    = adapter_ok && !adapter_ov;
  wire use_vbus     = !use_adapt && vbus_ok && !boost_closed;
  wire any_in       = use_adapt || use_vbus;
  wire [1:0] src_d  = use_adapt ? OVS_SRC_ADAPT :
                      use_vbus  ? OVS_SRC_VBUS  : OVS_SRC_BATT;
  wire batt_d       = !any_in || sys_over;

  wire [31:0] stat_word = {24'h000000, 1'b0, sys_over, vbus_ok, adapter_ok,
                           adapter_ov, adapt_if.closed, boost_closed, 1'b0};
  wire [31:0] rd_mux =
      sel_ctrl ? {30'h00000000, ctrl_q} :
      sel_stat ? stat_word :
      sel_irq  ? {30'h00000000, irq_q} :
      sel_mask ? {30'h00000000, mask_q} : 32'h00000000;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ctrl_q       <= `OVS_CTRL_RST;
      mask_q       <= `OVS_MASK_RST;
      irq_q        <= `OVS_IRQ_RST;
      rise_boost_q <= 1'b0;
      rise_adapt_q <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= ctrl_new;
      end
      if (wr_mask) begin
        mask_q <= avs_writedata[1:0];
      end
      irq_q        <= irq_d;
      rise_boost_q <= boost_rise;
      rise_adapt_q <= adapt_rise;
    end
  end

  // Answer one cycle after request
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ack_q   <= 1'b0;
      wait_q  <= 1'b1;
      rdata_q <= 32'h00000000;
      err_q   <= 1'b0;
    end else begin
      ack_q   <= req;
      wait_q  <= !req;
      rdata_q <= (req && avs_read) ? rd_mux : 32'h00000000;
      err_q   <= req && !mapped;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      boost_to_vbus_switch   <= 1'b0;
      adapter_to_vbus_switch <= 1'b0;
      vbus_charge_path       <= 1'b0;
      adapter_charge_path    <= 1'b0;
      charge_enable          <= 1'b0;
      battery_supply         <= 1'b1;
      sys_source             <= OVS_SRC_BATT;
      irq                    <= 1'b0;
    end else begin
      boost_to_vbus_switch   <= boost_closed;
      adapter_to_vbus_switch <= adapt_if.closed;
      vbus_charge_path       <= use_vbus;
      adapter_charge_path    <= use_adapt;
      charge_enable          <= any_in;
      battery_supply         <= batt_d;
      sys_source             <= src_d;
      irq                    <= irq_d_out;
    end
  end

  assign avs_readdata     = rdata_q;
  assign avs_waitrequest  = wait_q;
  assign avs_response_err = err_q;
endmodule

//--- ovs_top_sva.sv
// Checker for the VBUS switch and source select block
// Assumes binding to ovs_top; comparator inputs are raw asynchronous levels
`timescale 1ns/1ps
module ovs_top_sva #(
  parameter int OC_CYCLES = 20
) (
  input wire logic       core_clk,               // Clock
  input wire logic       nrst,                   // Sync reset, low
  input wire logic       boost_oc_in,            // Boost overload
  input wire logic       adapter_oc_in,          // Adapter overload
  input wire logic       adapter_ov_in,          // Adapter over-voltage
  input wire logic       adapter_valid_in,       // Adapter valid
  input wire logic       vbus_valid_in,          // VBUS valid
  input wire logic       sys_overload_in,        // System overload
  input wire logic       boost_to_vbus_switch,   // Boost switch
  input wire logic       adapter_to_vbus_switch, // Adapter switch
  input wire logic       vbus_charge_path,       // VBUS charging
  input wire logic       adapter_charge_path,    // Adapter charging
  input wire logic       charge_enable,          // Charging on
  input wire logic       battery_supply,         // Battery feeds system
  input wire logic [1:0] sys_source,             // Source code
  input wire logic       irq                     // Interrupt
);
  int cnt_b_q;
  int cnt_a_q;

  // ----------------------------------------
  // Overload run length while closed
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    cnt_b_q <= (nrst && boost_oc_in && boost_to_vbus_switch) ? cnt_b_q + 1 : 0;
    cnt_a_q <= (nrst && adapter_oc_in && adapter_to_vbus_switch) ? cnt_a_q + 1 : 0;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  excl_switch_a: assert property (
    !(boost_to_vbus_switch && adapter_to_vbus_switch)) else $error("both switches closed");
  ov_force_open_a: assert property (
    adapter_ov_in [*5] |-> !adapter_to_vbus_switch) else $error("adapter closed in ov");
  vbus_chg_block_a: assert property (
    boost_to_vbus_switch [*3] |-> !vbus_charge_path) else $error("vbus charge while boost");
  batt_only_a: assert property (
    (!adapter_valid_in && !vbus_valid_in) [*5] |->
      battery_supply && sys_source == 2'h0 && !charge_enable) else $error("no battery only");
  adapt_pref_a: assert property (
    (adapter_valid_in && !adapter_ov_in) [*5] |-> sys_source == 2'h3 && adapter_charge_path
      && charge_enable && !vbus_charge_path) else $error("adapter not preferred");
  vbus_select_a: assert property (
    (!adapter_valid_in && vbus_valid_in && !boost_to_vbus_switch) [*5] |->
      sys_source == 2'h1 && vbus_charge_path && charge_enable) else $error("vbus not used");
  overload_mix_a: assert property (
    (sys_overload_in && adapter_valid_in && !adapter_ov_in) [*5] |->
      battery_supply && charge_enable) else $error("battery not supplementing");
  boost_trip_a: assert property (
    cnt_b_q <= OC_CYCLES + 6) else $error("boost switch not tripped");
  adapt_trip_a: assert property (
    cnt_a_q <= OC_CYCLES + 6) else $error("adapter switch not tripped");

  cover property ($fell(boost_to_vbus_switch) && boost_oc_in);
  cover property ($fell(adapter_to_vbus_switch) && adapter_ov_in);
  cover property ($rose(irq));
endmodule

//--- ovs_top_tb.sv
// Self-checking bench for the VBUS switch and source select block
// Assumes ovs_top with a short overload count and Avalon-MM registers
`timescale 1ns/1ps
module ovs_top_tb;
  localparam int OC = 20;
  logic        core_clk;
  logic        nrst;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        rsp;
  logic        q_err;
  logic [3:0]  be;
  logic [1:0]  oc;
  logic [3:0]  src_in;
  logic [1:0]  sw;
  logic        vbus_chg;
  logic        adapt_chg;
  logic        chg_en;
  logic        batt;
  logic        irq;
  logic [1:0]  sys_source;
  logic [31:0] q;
  int          err_count;
  int          cmp_count;
  int          rnd;

  ovs_top #(.OC_CYCLES(OC)) ovs_top_inst (
    .core_clk(core_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(be),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response_err(rsp), .boost_oc_in(oc[0]), .adapter_oc_in(oc[1]),
    .adapter_ov_in(src_in[2]), .adapter_valid_in(src_in[0]), .vbus_valid_in(src_in[1]),
    .sys_overload_in(src_in[3]), .boost_to_vbus_switch(sw[0]),
    .adapter_to_vbus_switch(sw[1]), .vbus_charge_path(vbus_chg),
    .adapter_charge_path(adapt_chg), .charge_enable(chg_en), .battery_supply(batt),
    .sys_source(sys_source), .irq(irq));

  task automatic finish_test();
    if (err_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) begin
      chk(32'h1, 32'h0);
      finish_test();
    end else begin
      q = avs_readdata;
      q_err = rsp;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
    end
  endtask

  function automatic logic [1:0] e_src(input logic [3:0] s);
    if (s[0] && !s[2]) return 2'h3;
    return s[1] ? 2'h1 : 2'h0;
  endfunction

  // ----------------------------------------
  // Overload trip, interrupt and re-arm of one switch
  // ----------------------------------------
  task automatic trip(input int i);
    logic [31:0] b;
    b = 32'h1 << i;
    bus(1'b1, 4'h0, b);
    cyc(6);
    chk(sw[i], 1);
    oc[i] <= 1'b1;
    cyc(OC - 4);
    oc[i] <= 1'b0;
    cyc(3);
    oc[i] <= 1'b1;
    cyc(OC - 4);
    chk(sw[i], 1);
    cyc(12);
    chk(sw[i], 0);
    oc[i] <= 1'b0;
    bus(1'b0, 4'h8, 32'h0);
    chk(q, b);
    chk(irq, 0);
    bus(1'b1, 4'hC, b);
    cyc(3);
    chk(irq, 1);
    bus(1'b1, 4'h0, b);
    cyc(6);
    chk(sw[i], 0);
    bus(1'b1, 4'h0, 32'h0);
    bus(1'b1, 4'h0, b);
    cyc(6);
    chk(sw[i], 1);
    bus(1'b1, 4'h8, b);
    cyc(3);
    chk(irq, 0);
    bus(1'b1, 4'hC, 32'h0);
    bus(1'b1, 4'h0, 32'h0);
    cyc(6);
  endtask

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  initial begin
    repeat (100000) @(posedge core_clk);
    chk(32'h1, 32'h0);
    finish_test();
  end

  initial begin
    nrst = 1'b0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    be = 4'hF;
    oc = 2'h0;
    src_in = 4'h0;
    err_count = 0;
    cmp_count = 0;
    rnd = $urandom(33467);
    cyc(5);
    nrst <= 1'b1;
    bus(1'b0, 4'h8, 32'h0);
    chk(q, 0);
    bus(1'b0, 4'hC, 32'h0);
    chk(q, 0);
    bus(1'b1, 4'h2, 32'hFFFFFFFF);
    chk(q_err, 1);
    bus(1'b0, 4'h0, 32'h0);
    chk(q, 0);
    chk(q_err, 0);
    // Write with byte lane 0 off is ignored
    be <= 4'hE;
    bus(1'b1, 4'h0, 32'h3);
    be <= 4'hF;
    bus(1'b0, 4'h0, 32'h0);
    chk(q, 0);
    bus(1'b1, 4'h0, 32'h3);
    cyc(6);
    chk(sw, 2'h1);
    bus(1'b0, 4'h4, 32'h0);
    chk(q, 32'h2);
    bus(1'b1, 4'h0, 32'h2);
    cyc(6);
    chk(sw, 2'h2);
    src_in <= 4'h4;
    cyc(6);
    chk(sw, 2'h0);
    bus(1'b0, 4'h4, 32'h0);
    chk(q, 32'h8);
    src_in <= 4'h0;
    cyc(6);
    chk(sw, 2'h2);
    bus(1'b1, 4'h0, 32'h0);
    cyc(6);
    chk(sw, 2'h0);
    trip(0);
    trip(1);
    // Every input combination, then random ones
    for (int k = 0; k < 40; k++) begin
      src_in <= (k < 16) ? k[3:0] : 4'($urandom);
      cyc(8);
      chk(sys_source, e_src(src_in));
      chk(batt, e_src(src_in) == 2'h0 || src_in[3]);
      chk({chg_en, adapt_chg, vbus_chg}, {e_src(src_in) != 2'h0, e_src(src_in) == 2'h3,
          e_src(src_in) == 2'h1});
    end
    src_in <= 4'h2;
    bus(1'b1, 4'h0, 32'h1);
    cyc(8);
    chk(vbus_chg, 0);
    finish_test();
  end
endmodule

bind ovs_top ovs_top_sva #(.OC_CYCLES(OC_CYCLES)) ovs_top_sva_inst (
  .core_clk(core_clk), .nrst(nrst), .boost_oc_in(boost_oc_in),
  .adapter_oc_in(adapter_oc_in), .adapter_ov_in(adapter_ov_in),
  .adapter_valid_in(adapter_valid_in), .vbus_valid_in(vbus_valid_in),
  .sys_overload_in(sys_overload_in), .boost_to_vbus_switch(boost_to_vbus_switch),
  .adapter_to_vbus_switch(adapter_to_vbus_switch), .vbus_charge_path(vbus_charge_path),
  .adapter_charge_path(adapter_charge_path), .charge_enable(charge_enable),
  .battery_supply(battery_supply), .sys_source(sys_source), .irq(irq));
